// ===== dma_setup_pkg.sv
`default_nettype none
package dma_setup_pkg;
  // Avalon word address: channel in the upper bits, register in the low three
  localparam int         BUS_AW         = 8;
  localparam int         REG_IDX_W      = 3;
  localparam int         DATA_W         = 32;
  localparam int         ADDR_W         = 24;
  localparam int         HIGH_USED_W    = 8;
  localparam int         FIFO_DEPTH     = 4;
  localparam int         NUM_CH         = 6;

  localparam logic [2:0] OFS_SRC_LO     = 3'h0;
  localparam logic [2:0] OFS_SRC_HI     = 3'h1;
  localparam logic [2:0] OFS_DST_LO     = 3'h2;
  localparam logic [2:0] OFS_DST_HI     = 3'h3;
  localparam logic [2:0] OFS_ELEMS      = 3'h4;
  localparam logic [2:0] OFS_FRAMES     = 3'h5;
  localparam logic [2:0] OFS_CTRL       = 3'h6;
  localparam logic [2:0] OFS_STAT       = 3'h7;

  // Control word: start, element data type, source port, destination port
  localparam int         CTRL_START_BIT = 0;
  localparam int         CTRL_TYPE_LSB  = 1;
  localparam int         CTRL_SPORT_LSB = 3;
  localparam int         CTRL_DPORT_LSB = 5;
  localparam logic [6:0] CTRL_RESET     = 7'h00;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_DONE_BIT  = 1;
  localparam int         STAT_TOUT_BIT  = 2;

  localparam logic [1:0] DT_8           = 2'h0;
  localparam logic [1:0] DT_16          = 2'h1;
  localparam logic [1:0] DT_32          = 2'h2;

  localparam logic [1:0] PORT_SARAM     = 2'h0;
  localparam logic [1:0] PORT_DARAM     = 2'h1;
  localparam logic [1:0] PORT_EXT_MEM   = 2'h2;
  localparam logic [1:0] PORT_PERIPH    = 2'h3;

  // Highest valid byte address of each port
  localparam logic [23:0] SARAM_TOP     = 24'h03FFFF;
  localparam logic [23:0] DARAM_TOP     = 24'h00FFFF;
  localparam logic [23:0] EXT_MEM_TOP   = 24'hFFFFFF;
  localparam logic [23:0] PERIPH_TOP    = 24'h01FFFF;
  // System-control window the peripheral port may not touch
  localparam logic [23:0] PROT_LO       = 24'h000000;
  localparam logic [23:0] PROT_HI       = 24'h007FFF;
endpackage : dma_setup_pkg
`default_nettype wire

// ===== dma_elem_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module dma_elem_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and control
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  input  wire logic             clr_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_r != (PW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  always_ff @(posedge core_clk_in) begin
    if (ce_in && push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (ce_in) begin
      if (clr_in) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
        count_r  <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= ptr_inc(wr_ptr_r);
        end
        if (pop) begin
          rd_ptr_r <= ptr_inc(rd_ptr_r);
        end
        if (push && !pop) begin
          count_r <= count_r + (PW+1)'(1);
        end else if (pop && !push) begin
          count_r <= count_r - (PW+1)'(1);
        end
      end
    end
  end
endmodule : dma_elem_fifo
`default_nettype wire

// ===== dma_channel_addr_count_setup.sv
// Overview of operation
// - Every channel owns its own setup registers
// - Source start is upper over lower register
// - Destination start is upper over lower register
// - Out-of-range port address flags time-out error
// - Peripheral port cannot reach system-control registers
// - Element count gives elements per frame
// - Frame count gives frames per block
// - Count registers are not reset
// - Start address registers are 16-bit, not reset
// - Post-increment steps by 1, 2 or 4
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_addr_count_setup
  import dma_setup_pkg::*;
#(
  parameter int NCH = dma_setup_pkg::NUM_CH
) (
  // Clock, reset, enable
  input  wire logic                             core_clk_in,
  input  wire logic                             sys_rst_in,
  input  wire logic                             ce_in,
  // Avalon-MM slave
  input  wire logic [dma_setup_pkg::BUS_AW-1:0] avs_address_in,
  input  wire logic                             avs_read_in,
  input  wire logic                             avs_write_in,
  input  wire logic [dma_setup_pkg::DATA_W-1:0] avs_writedata_in,
  output logic [dma_setup_pkg::DATA_W-1:0]      avs_readdata_out,
  output logic                                  avs_waitrequest_out,
  // Memory and peripheral port access
  output logic                                  mem_req_out,
  output logic                                  mem_we_out,
  output logic [1:0]                            mem_port_out,
  output logic [1:0]                            mem_size_out,
  output logic [dma_setup_pkg::ADDR_W-1:0]      mem_addr_out,
  output logic [dma_setup_pkg::DATA_W-1:0]      mem_wdata_out,
  input  wire logic                             mem_ack_in,
  input  wire logic                             mem_err_in,
  input  wire logic [dma_setup_pkg::DATA_W-1:0] mem_rdata_in,
  // Engine status
  output logic                                  busy_out,
  output logic                                  error_out
);
  import dma_setup_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_ISSUE, ST_RD, ST_WR} eng_state_e;
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  // Per-channel setup; address and count registers left unreset on purpose
  logic [15:0] src_lo_r [NCH];
  logic [15:0] src_hi_r [NCH];
  logic [15:0] dst_lo_r [NCH];
  logic [15:0] dst_hi_r [NCH];
  logic [15:0] elems_r  [NCH];
  logic [15:0] frames_r [NCH];
  logic [6:0]  ctrl_r   [NCH];
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] done_r;
  logic [NCH-1:0] tout_r;

  logic              wait_r;
  logic [31:0]       rdata_r;
  logic              req;
  logic              take_wr;
  logic [BUS_AW-1:0] bus_ch;
  logic [2:0]        bus_reg;
  logic              bus_hit;
  logic [31:0]       rd_mux;

  eng_state_e        st_r;
  logic [CW-1:0]     cur_ch_r;
  logic [ADDR_W-1:0] src_wa_r;
  logic [ADDR_W-1:0] dst_wa_r;
  logic [15:0]       en_l_r;
  logic [15:0]       rd_e_r;
  logic [15:0]       rd_f_r;
  logic [15:0]       wr_e_r;
  logic [15:0]       wr_f_r;
  logic              rd_fin_r;
  logic              wr_last;
  logic [1:0]        dt_r;
  logic [1:0]        sport_r;
  logic [1:0]        dport_r;
  logic              req_r;
  logic              we_r;
  logic [1:0]        port_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0]       wdata_r;
  logic              busy_r;
  logic              err_r;

  logic              grant;
  logic [CW-1:0]     grant_ch;
  logic              fin_ok;
  logic              fin_err;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [31:0]       fifo_out_data;
  logic              do_rd;
  logic              do_wr;

  // Post-increment step per element data type
  function automatic logic [ADDR_W-1:0] step(input logic [1:0] dt);
    case (dt)
      DT_16:   step = 24'h000002;
      DT_32:   step = 24'h000004;
      default: step = 24'h000001;
    endcase
  endfunction : step

  // Whole element inside the port, and off-limits window kept from the peripheral port
  function automatic logic addr_ok(input logic [1:0] port, input logic [ADDR_W-1:0] a,
                                   input logic [1:0] dt);
    logic [ADDR_W:0]   last;
    logic [ADDR_W-1:0] top;
    last = {1'b0, a} + {1'b0, step(dt)} - 25'h0000001;
    case (port)
      PORT_SARAM: top = SARAM_TOP;
      PORT_DARAM: top = DARAM_TOP;
      PORT_EXT_MEM: top = EXT_MEM_TOP;
      default:    top = PERIPH_TOP;
    endcase
    addr_ok = (last <= {1'b0, top});
    if (port == PORT_PERIPH && a <= PROT_HI && last >= {1'b0, PROT_LO}) begin
      addr_ok = 1'b0;
    end
  endfunction : addr_ok

  // Element and frame countdown: {block finished, elements left, frames left}
  function automatic logic [32:0] count_next(input logic [15:0] e, input logic [15:0] f,
                                             input logic [15:0] en);
    if (e != 16'h0001) begin
      count_next = {1'b0, e - 16'h0001, f};
    end else if (f != 16'h0001) begin
      count_next = {1'b0, en, f - 16'h0001};
    end else begin
      count_next = {1'b1, e, f};
    end
  endfunction : count_next

  // Register bus: one wait cycle, then the answer
  assign req     = avs_read_in || avs_write_in;
  assign take_wr = ce_in && avs_write_in && !wait_r;
  assign bus_ch  = avs_address_in >> REG_IDX_W;
  assign bus_reg = avs_address_in[REG_IDX_W-1:0];
  assign bus_hit = (bus_ch < BUS_AW'(NCH));

  always_comb begin
    rd_mux = 32'h00000000;
    if (bus_hit) begin
      case (bus_reg)
        OFS_SRC_LO: rd_mux[15:0] = src_lo_r[bus_ch[CW-1:0]];
        OFS_SRC_HI: rd_mux[15:0] = src_hi_r[bus_ch[CW-1:0]];
        OFS_DST_LO: rd_mux[15:0] = dst_lo_r[bus_ch[CW-1:0]];
        OFS_DST_HI: rd_mux[15:0] = dst_hi_r[bus_ch[CW-1:0]];
        OFS_ELEMS:  rd_mux[15:0] = elems_r[bus_ch[CW-1:0]];
        OFS_FRAMES: rd_mux[15:0] = frames_r[bus_ch[CW-1:0]];
        OFS_CTRL: begin
          rd_mux[6:0]            = ctrl_r[bus_ch[CW-1:0]];
          rd_mux[CTRL_START_BIT] = pend_r[bus_ch[CW-1:0]];
        end
        default: begin
          rd_mux[STAT_BUSY_BIT] = busy_r && (cur_ch_r == bus_ch[CW-1:0]);
          rd_mux[STAT_DONE_BIT] = done_r[bus_ch[CW-1:0]];
          rd_mux[STAT_TOUT_BIT] = tout_r[bus_ch[CW-1:0]];
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else if (ce_in) begin
      wait_r <= !(req && wait_r);
      if (avs_read_in && wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Setup registers of every channel, no reset
  always_ff @(posedge core_clk_in) begin
    if (take_wr && bus_hit) begin
      case (bus_reg)
        OFS_SRC_LO: src_lo_r[bus_ch[CW-1:0]] <= avs_writedata_in[15:0];
        OFS_SRC_HI: src_hi_r[bus_ch[CW-1:0]] <= avs_writedata_in[15:0];
        OFS_DST_LO: dst_lo_r[bus_ch[CW-1:0]] <= avs_writedata_in[15:0];
        OFS_DST_HI: dst_hi_r[bus_ch[CW-1:0]] <= avs_writedata_in[15:0];
        OFS_ELEMS:  elems_r[bus_ch[CW-1:0]]  <= avs_writedata_in[15:0];
        OFS_FRAMES: frames_r[bus_ch[CW-1:0]] <= avs_writedata_in[15:0];
        default: ;
      endcase
    end
  end

  // Control and sticky status; hardware set wins over software clear
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_r[i] <= CTRL_RESET;
      end
      pend_r <= '0;
      done_r <= '0;
      tout_r <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < NCH; i++) begin
        if (grant && grant_ch == CW'(i)) begin
          pend_r[i] <= 1'b0;
        end
        if (take_wr && bus_hit && bus_ch[CW-1:0] == CW'(i)) begin
          if (bus_reg == OFS_CTRL) begin
            ctrl_r[i] <= {avs_writedata_in[6:1], 1'b0};
            if (avs_writedata_in[CTRL_START_BIT]) begin
              pend_r[i] <= 1'b1;
            end
          end
          if (bus_reg == OFS_STAT) begin
            if (avs_writedata_in[STAT_DONE_BIT]) begin
              done_r[i] <= 1'b0;
            end
            if (avs_writedata_in[STAT_TOUT_BIT]) begin
              tout_r[i] <= 1'b0;
            end
          end
        end
        if (fin_ok && cur_ch_r == CW'(i)) begin
          done_r[i] <= 1'b1;
        end
        if (fin_err && cur_ch_r == CW'(i)) begin
          tout_r[i] <= 1'b1;
        end
      end
    end
  end

  // Lowest pending channel starts next
  always_comb begin
    grant    = 1'b0;
    grant_ch = '0;
    if (st_r == ST_IDLE) begin
      for (int i = NCH - 1; i >= 0; i--) begin
        if (pend_r[i]) begin
          grant    = 1'b1;
          grant_ch = CW'(i);
        end
      end
    end
  end

  // Reads fill the buffer whenever it has room; writes drain it only once it is full or all reads are done
  assign do_rd    = (st_r == ST_ISSUE) && !rd_fin_r && fifo_in_ready;
  assign do_wr    = (st_r == ST_ISSUE) && !do_rd && fifo_out_valid;
  assign fifo_pop = ce_in && do_wr && addr_ok(dport_r, dst_wa_r, dt_r);
  // Last write of the block is the one acked with both countdowns at one
  assign wr_last  = (wr_e_r == 16'h0001) && (wr_f_r == 16'h0001);
  assign fin_ok   = (st_r == ST_WR) && mem_ack_in && !mem_err_in && wr_last;
  assign fin_err  = ((st_r == ST_RD || st_r == ST_WR) && mem_err_in)
                    || (do_rd && !addr_ok(sport_r, src_wa_r, dt_r))
                    || (do_wr && !addr_ok(dport_r, dst_wa_r, dt_r));

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_r     <= ST_IDLE;
      cur_ch_r <= '0;
      src_wa_r <= '0;
      dst_wa_r <= '0;
      en_l_r   <= 16'h0001;
      rd_e_r   <= 16'h0001;
      rd_f_r   <= 16'h0001;
      wr_e_r   <= 16'h0001;
      wr_f_r   <= 16'h0001;
      rd_fin_r <= 1'b0;
      dt_r     <= DT_8;
      sport_r  <= PORT_SARAM;
      dport_r  <= PORT_SARAM;
      req_r    <= 1'b0;
      we_r     <= 1'b0;
      port_r   <= PORT_SARAM;
      addr_r   <= '0;
      wdata_r  <= 32'h00000000;
      busy_r   <= 1'b0;
      err_r    <= 1'b0;
    end else if (ce_in) begin
      case (st_r)
        ST_IDLE: begin
          if (grant) begin
            cur_ch_r <= grant_ch;
            busy_r   <= 1'b1;
            err_r    <= 1'b0;
            st_r     <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          src_wa_r <= {src_hi_r[cur_ch_r][HIGH_USED_W-1:0], src_lo_r[cur_ch_r]};
          dst_wa_r <= {dst_hi_r[cur_ch_r][HIGH_USED_W-1:0], dst_lo_r[cur_ch_r]};
          en_l_r   <= elems_r[cur_ch_r];
          rd_e_r   <= elems_r[cur_ch_r];
          wr_e_r   <= elems_r[cur_ch_r];
          rd_f_r   <= frames_r[cur_ch_r];
          wr_f_r   <= frames_r[cur_ch_r];
          rd_fin_r <= 1'b0;
          dt_r     <= ctrl_r[cur_ch_r][CTRL_TYPE_LSB +: 2];
          sport_r  <= ctrl_r[cur_ch_r][CTRL_SPORT_LSB +: 2];
          dport_r  <= ctrl_r[cur_ch_r][CTRL_DPORT_LSB +: 2];
          st_r     <= ST_ISSUE;
        end
        ST_ISSUE: begin
          if (fin_err) begin
            busy_r <= 1'b0;
            err_r  <= 1'b1;
            st_r   <= ST_IDLE;
          end else if (do_rd) begin
            req_r  <= 1'b1;
            we_r   <= 1'b0;
            port_r <= sport_r;
            addr_r <= src_wa_r;
            st_r   <= ST_RD;
          end else if (do_wr) begin
            req_r   <= 1'b1;
            we_r    <= 1'b1;
            port_r  <= dport_r;
            addr_r  <= dst_wa_r;
            wdata_r <= fifo_out_data;
            st_r    <= ST_WR;
          end
        end
        ST_RD: begin
          if (mem_err_in) begin
            req_r  <= 1'b0;
            busy_r <= 1'b0;
            err_r  <= 1'b1;
            st_r   <= ST_IDLE;
          end else if (mem_ack_in) begin
            req_r    <= 1'b0;
            src_wa_r <= src_wa_r + step(dt_r);
            {rd_fin_r, rd_e_r, rd_f_r} <= count_next(rd_e_r, rd_f_r, en_l_r);
            st_r     <= ST_ISSUE;
          end
        end
        ST_WR: begin
          if (mem_err_in) begin
            req_r  <= 1'b0;
            busy_r <= 1'b0;
            err_r  <= 1'b1;
            st_r   <= ST_IDLE;
          end else if (mem_ack_in) begin
            req_r    <= 1'b0;
            dst_wa_r <= dst_wa_r + step(dt_r);
            {wr_e_r, wr_f_r} <= 32'(count_next(wr_e_r, wr_f_r, en_l_r));
            if (wr_last) begin
              busy_r <= 1'b0;
              st_r   <= ST_IDLE;
            end else begin
              st_r <= ST_ISSUE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  dma_elem_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_elem_fifo (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .ce_in         (ce_in),
    .clr_in        (st_r == ST_LOAD),
    .in_valid_in   ((st_r == ST_RD) && mem_ack_in && !mem_err_in),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mem_rdata_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  assign avs_readdata_out    = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign mem_req_out         = req_r;
  assign mem_we_out          = we_r;
  assign mem_port_out        = port_r;
  assign mem_size_out        = dt_r;
  assign mem_addr_out        = addr_r;
  assign mem_wdata_out       = wdata_r;
  assign busy_out            = busy_r;
  assign error_out           = err_r;
endmodule : dma_channel_addr_count_setup
`default_nettype wire

// ===== dma_setup_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dma_setup_properties
  import dma_setup_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        ce_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [1:0]  mem_port_out,
  input wire logic [1:0]  mem_size_out,
  input wire logic [23:0] mem_addr_out,
  input wire logic        mem_ack_in,
  input wire logic        mem_err_in,
  input wire logic        busy_out,
  input wire logic        error_out
);
  logic [23:0] last_rd_r;
  logic        rd_seen_r;
  logic [23:0] top;
  logic [24:0] last_byte;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !busy_out) rd_seen_r <= 1'b0;
    else if (mem_req_out && !mem_we_out && mem_ack_in) rd_seen_r <= 1'b1;
  end
  always_ff @(posedge core_clk_in) begin
    if (mem_req_out && !mem_we_out && mem_ack_in) last_rd_r <= mem_addr_out;
  end
  always_comb begin
    case (mem_port_out)
      PORT_SARAM: top = SARAM_TOP;
      PORT_DARAM: top = DARAM_TOP;
      PORT_EXT_MEM: top = EXT_MEM_TOP;
      default:    top = PERIPH_TOP;
    endcase
    last_byte = {1'b0, mem_addr_out} + ((25'h1 << mem_size_out) - 25'h1);
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence err_taken;
    mem_req_out && mem_err_in;
  endsequence
  sequence flag_raised;
    ##[1:4] (error_out && !busy_out);
  endsequence
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in
    |=> !avs_waitrequest_out) else $error("bus request not answered");
  wait_release_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  req_hold_a: assert property (mem_req_out && !mem_ack_in && !mem_err_in
    |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out)) else $error("request not held");
  req_drop_a: assert property (mem_req_out && (mem_ack_in || mem_err_in) |=> !mem_req_out)
    else $error("request kept after answer");
  req_busy_a: assert property (mem_req_out |-> busy_out) else $error("request while idle");
  step_size_a: assert property ($rose(mem_req_out) && !mem_we_out && rd_seen_r
    |-> mem_addr_out == last_rd_r + (24'h1 << mem_size_out)) else $error("bad address step");
  periph_guard_a: assert property (mem_req_out && mem_port_out == PORT_PERIPH |-> mem_addr_out > PROT_HI)
    else $error("peripheral access to protected window");
  port_range_a: assert property (mem_req_out |-> last_byte <= {1'b0, top})
    else $error("access beyond port range");
  error_flag_a: assert property (err_taken |-> flag_raised) else $error("time-out not flagged");
endmodule : dma_setup_properties
bind dma_channel_addr_count_setup dma_setup_properties dma_setup_properties_i (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .mem_req_out(mem_req_out),
  .mem_we_out(mem_we_out), .mem_port_out(mem_port_out), .mem_size_out(mem_size_out),
  .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in), .mem_err_in(mem_err_in),
  .busy_out(busy_out), .error_out(error_out));
`default_nettype wire

// ===== dma_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module dma_mem_model (
  input  wire logic        core_clk_in,
  input  wire logic        mem_req_in,
  input  wire logic [23:0] mem_addr_in,
  input  wire logic [7:0]  lat_in,
  input  wire logic        fail_in,
  output logic             ack_out,
  output logic             err_out,
  output logic [31:0]      rdata_out
);
  logic [7:0] cnt_r;
  always_ff @(posedge core_clk_in) begin
    ack_out <= 1'b0;
    err_out <= 1'b0;
    cnt_r   <= 8'h00;
    if (mem_req_in && !ack_out && !err_out) begin
      if (cnt_r >= lat_in) begin
        ack_out <= !fail_in;
        err_out <= fail_in;
      end else cnt_r <= cnt_r + 8'h01;
    end
  end
  // Data follows the address, inverted outside an answer
  assign rdata_out = ack_out ? {8'h00, mem_addr_in} : {8'hFF, ~mem_addr_in};
endmodule : dma_mem_model
`default_nettype wire

// ===== tb_dma_channel_addr_count_setup.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dma_channel_addr_count_setup;
  import dma_setup_pkg::*;
  logic        clk, rst, rd, wr, wreq, req, we, ack, err, busy, error, fail, ce;
  logic [7:0]  adr, lat;
  logic [31:0] wd, rdat, mwd, mrd, mask;
  logic [1:0]  port, size;
  logic [23:0] maddr, x_src, x_dst, stp;
  int          fail_count, check_count, rd_n, wr_n, cyc;
  dma_channel_addr_count_setup dma_channel_addr_count_setup_i (
    .core_clk_in(clk), .sys_rst_in(rst), .ce_in(ce), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .mem_req_out(req), .mem_we_out(we), .mem_port_out(port), .mem_size_out(size), .mem_addr_out(maddr),
    .mem_wdata_out(mwd), .mem_ack_in(ack), .mem_err_in(err), .mem_rdata_in(mrd), .busy_out(busy),
    .error_out(error));
  dma_mem_model dma_mem_model_i (.core_clk_in(clk), .mem_req_in(req), .mem_addr_in(maddr), .lat_in(lat),
    .fail_in(fail), .ack_out(ack), .err_out(err), .rdata_out(mrd));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      conclude();
    end
    if (req && ack && !we) begin
      chk(32'(maddr), 32'(x_src + stp * 24'(rd_n)));
      rd_n++;
    end
    if (req && ack && we) begin
      chk(32'(maddr), 32'(x_dst + stp * 24'(wr_n)));
      chk(mwd & mask, {8'h00, x_src + stp * 24'(wr_n)} & mask);
      wr_n++;
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) chk(32'h0, 32'h1);
  endtask : bus
  task automatic wreg(input logic [4:0] c, input logic [2:0] r, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, {c, r}, {16'h0000, d}, q);
  endtask : wreg
  task automatic rreg(input logic [4:0] c, input logic [2:0] r, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, {c, r}, 32'h0, q);
    chk(q, e);
  endtask : rreg
  task automatic blk(input logic [4:0] c, input logic [1:0] dt, input logic [1:0] sp, input logic [1:0] dp,
                     input logic [23:0] s, input logic [23:0] t, input logic [15:0] en, input logic [15:0] fn,
                     input logic [7:0] l, input logic f, input logic e);
    logic [31:0] q;
    int n;
    x_src = s;
    x_dst = t;
    stp = 24'h1 << dt;
    mask = (dt == DT_32) ? 32'hFFFFFFFF : (dt == DT_16) ? 32'h0000FFFF : 32'h000000FF;
    rd_n = 0;
    wr_n = 0;
    lat <= l;
    fail <= f;
    wreg(c, OFS_SRC_LO, s[15:0]);
    wreg(c, OFS_SRC_HI, {8'h00, s[23:16]});
    wreg(c, OFS_DST_LO, t[15:0]);
    wreg(c, OFS_DST_HI, {8'h00, t[23:16]});
    wreg(c, OFS_ELEMS, en);
    wreg(c, OFS_FRAMES, fn);
    wreg(c, OFS_CTRL, {9'h000, dp, sp, dt, 1'b1});
    n = 0;
    do begin
      bus(1'b0, {c, OFS_STAT}, 32'h0, q);
      n++;
    end while (q[2:1] == 2'b00 && n < 300);
    chk(32'(q[STAT_TOUT_BIT]), 32'(e));
    chk(32'(q[STAT_DONE_BIT]), 32'(!e));
    chk(32'(busy), 32'h0);
    chk(32'(error), 32'(e));
    if (e) chk(32'(wr_n), 32'h0);
    else begin
      chk(32'(wr_n), 32'(en) * 32'(fn));
      chk(32'(rd_n), 32'(en) * 32'(fn));
    end
    rreg(c, OFS_SRC_LO, {16'h0000, s[15:0]});
    rreg(c, OFS_DST_HI, {24'h000000, t[23:16]});
    wreg(c, OFS_STAT, 16'h0006);
  endtask : blk
  task automatic t_regs;
    rreg(5'd0, OFS_CTRL, 32'h0);
    for (int r = 0; r < 6; r++) begin
      wreg(5'd0, 3'(r), (r == 1 || r == 3) ? 16'h00FF : 16'hFFFF - 16'(r));
      wreg(5'd3, 3'(r), 16'h0001 + 16'(r));
    end
    for (int r = 0; r < 6; r++) begin
      rreg(5'd0, 3'(r), (r == 1 || r == 3) ? 32'h00FF : 32'hFFFF - 32'(r));
      rreg(5'd3, 3'(r), 32'h0001 + 32'(r));
    end
    wreg(5'd6, OFS_SRC_LO, 16'h1234);
    rreg(5'd6, OFS_SRC_LO, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_copy;
    blk(5'd2, DT_16, PORT_SARAM, PORT_EXT_MEM, 24'h010100, 24'h200000, 16'd3, 16'd2, 8'd0, 1'b0, 1'b0);
    $display("test copy done");
  endtask : t_copy
  task automatic t_steps;
    blk(5'd1, DT_8, PORT_DARAM, PORT_SARAM, 24'h00FFF0, 24'h03FF00, 16'd5, 16'd1, 8'd3, 1'b0, 1'b0);
    blk(5'd4, DT_32, PORT_EXT_MEM, PORT_DARAM, 24'hFF0000, 24'h000100, 16'd6, 16'd1, 8'd1, 1'b0, 1'b0);
    $display("test steps done");
  endtask : t_steps
  task automatic t_fault;
    blk(5'd0, DT_16, PORT_SARAM, PORT_DARAM, 24'h000000, 24'h010000, 16'd2, 16'd1, 8'd0, 1'b0, 1'b1);
    blk(5'd0, DT_16, PORT_PERIPH, PORT_SARAM, 24'h001000, 24'h000200, 16'd2, 16'd1, 8'd0, 1'b0, 1'b1);
    blk(5'd0, DT_16, PORT_SARAM, PORT_SARAM, 24'h000400, 24'h000800, 16'd2, 16'd1, 8'd2, 1'b1, 1'b1);
    blk(5'd0, DT_16, PORT_SARAM, PORT_SARAM, 24'h000400, 24'h000800, 16'd1, 16'd1, 8'd0, 1'b0, 1'b0);
    blk(5'd5, DT_16, PORT_SARAM, PORT_PERIPH, 24'h000400, 24'h008000, 16'd2, 16'd1, 8'd0, 1'b0, 1'b0);
    $display("test fault done");
  endtask : t_fault
  task automatic t_freeze;
    ce <= 1'b0;
    wr <= 1'b1;
    adr <= {5'd1, OFS_SRC_LO};
    wd <= 32'h0000ABCD;
    repeat (6) @(posedge clk);
    chk(32'(wreq), 32'h1);
    ce <= 1'b1;
    do @(posedge clk);
    while (wreq !== 1'b0);
    wr <= 1'b0;
    rreg(5'd1, OFS_SRC_LO, 32'h0000ABCD);
    $display("test freeze done");
  endtask : t_freeze
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    lat = 8'h00;
    fail = 1'b0;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_freeze();
    t_copy();
    t_steps();
    t_fault();
    conclude();
  end
endmodule : tb_dma_channel_addr_count_setup
`default_nettype wire
